//--- verilog/rtc_irq_serial.sv
`timescale 1ns/1ns
module rtc_irq_serial #(
	parameter int unsigned RTN64_CYC = rtc_pkg::RTN_64_NS / rtc_pkg::CLK_NS,
	parameter int unsigned RTN1_CYC  = rtc_pkg::RTN_1_NS / rtc_pkg::CLK_NS
) (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       nrst,
	// Three-wire serial pins
	input  wire logic       serClk,
	input  wire logic       serSel,
	input  wire logic       serDin,
	output logic            serDout,
	output logic            serDoutOe,
	// Open-drain interrupt pin
	output logic            irqOutN,
	output logic            irqOe,
	// Configuration from surrounding logic
	input  wire logic       freqOutEn,
	input  wire logic [1:0] intervalSrcSel,
	input  wire logic       freqWave,
	// Time base events and counters
	input  wire logic       timerZero,
	input  wire logic       secCarry,
	input  wire logic [7:0] curMin,
	input  wire logic [7:0] curHour,
	input  wire logic [6:0] curWday,
	input  wire logic [7:0] curDay,
	// Status
	output logic            timerFlag,
	output logic            alarmFlag
);
	rtc_pkg::rtc_state_type st_r;
	rtc_pkg::rtc_state_type st_nxt;
	logic                    rise;
	logic                    alarmHit;
	logic [rtc_pkg::RTN_W-1:0] rtnLen;
	logic [7:0]              ctl;
	logic [7:0]              nctl;
	logic [7:0]              wd;
	logic                    fldMin;
	logic                    fldHour;
	logic                    fldWday;
	logic                    fldDay;

	assign rise = st_r.sclkS2 & ~st_r.sclkD;
	assign ctl  = st_r.regs[rtc_pkg::A_CTRL];

	// ---------------------------------------------
	// Alarm compare
	// ---------------------------------------------
	always_comb begin
		fldMin  = st_r.regs[rtc_pkg::A_MIN][rtc_pkg::B_MASK] |
			(st_r.regs[rtc_pkg::A_MIN][6:0] == curMin[6:0]);
		fldHour = st_r.regs[rtc_pkg::A_HOUR][rtc_pkg::B_MASK] |
			(st_r.regs[rtc_pkg::A_HOUR][6:0] == curHour[6:0]);
		fldWday = st_r.regs[rtc_pkg::A_WDAY][rtc_pkg::B_MASK] |
			(|(st_r.regs[rtc_pkg::A_WDAY][6:0] & curWday));
		fldDay  = st_r.regs[rtc_pkg::A_DAY][rtc_pkg::B_MASK] |
			(st_r.regs[rtc_pkg::A_DAY][6:0] == curDay[6:0]);
		alarmHit = secCarry & fldMin & fldHour & fldWday & fldDay;
	end

	// ---------------------------------------------
	// Auto-return length
	// ---------------------------------------------
	always_comb begin
		if (intervalSrcSel == rtc_pkg::SRC_64) begin
			rtnLen = rtc_pkg::RTN_W'(RTN64_CYC);
		end else if (intervalSrcSel == rtc_pkg::SRC_1) begin
			rtnLen = rtc_pkg::RTN_W'(RTN1_CYC);
		end else begin
			// 4096 Hz and 1/60 Hz share the short pulse
			rtnLen = rtc_pkg::RTN_W'(rtc_pkg::RTN_FAST_CYC);
		end
	end

	// ---------------------------------------------
	// Next state
	// ---------------------------------------------
	always_comb begin
		st_nxt = st_r;
		wd     = '0;
		nctl   = '0;
		// First stage feeds only the second
		st_nxt.sclkS1 = serClk;
		st_nxt.sclkS2 = st_r.sclkS1;
		st_nxt.sclkD  = st_r.sclkS2;
		st_nxt.csS1   = serSel;
		st_nxt.csS2   = st_r.csS1;
		st_nxt.sdiS1  = serDin;
		st_nxt.sdiS2  = st_r.sdiS1;

		if (!st_r.csS2) begin
			// Partial byte never reaches the array
			st_nxt.ser    = rtc_pkg::SER_HDR;
			st_nxt.bitCnt = '0;
			st_nxt.sdoOe  = 1'b0;
		end else if (rise) begin
			st_nxt.bitCnt = st_r.bitCnt + 3'h1;
			st_nxt.shift  = {st_r.sdiS2, st_r.shift[7:1]};
			case (st_r.ser)
				rtc_pkg::SER_HDR: begin
					if (st_r.bitCnt == rtc_pkg::NIB_LAST) begin
						st_nxt.isRead = (st_nxt.shift[7:4] == rtc_pkg::MODE_RD);
						if (st_nxt.shift[7:4] == rtc_pkg::MODE_WR ||
							st_nxt.shift[7:4] == rtc_pkg::MODE_RD) begin
							st_nxt.ser = rtc_pkg::SER_ADR;
						end else begin
							st_nxt.ser = rtc_pkg::SER_SKIP;
						end
					end
				end
				rtc_pkg::SER_ADR: begin
					if (st_r.bitCnt == rtc_pkg::BYTE_LAST) begin
						st_nxt.ptr    = st_nxt.shift[7:4];
						st_nxt.rdByte = st_r.regs[st_nxt.shift[7:4]];
						st_nxt.ser    = st_r.isRead ? rtc_pkg::SER_RD : rtc_pkg::SER_WR;
					end
				end
				rtc_pkg::SER_WR: begin
					if (st_r.bitCnt == rtc_pkg::BYTE_LAST) begin
						wd = st_nxt.shift;
						if (st_r.ptr == rtc_pkg::A_CTRL) begin
							// Flags only take zeros from software
							wd[rtc_pkg::B_TMR_FLG] = wd[rtc_pkg::B_TMR_FLG] &
								ctl[rtc_pkg::B_TMR_FLG];
							wd[rtc_pkg::B_ALM_FLG] = wd[rtc_pkg::B_ALM_FLG] &
								ctl[rtc_pkg::B_ALM_FLG];
						end
						st_nxt.regs[st_r.ptr] = wd;
						st_nxt.ptr = st_r.ptr + 4'h1;
					end
				end
				rtc_pkg::SER_RD: begin
					st_nxt.sdo   = st_r.rdByte[st_r.bitCnt];
					st_nxt.sdoOe = 1'b1;
					if (st_r.bitCnt == rtc_pkg::BYTE_LAST) begin
						st_nxt.ptr    = st_r.ptr + 4'h1;
						st_nxt.rdByte = st_r.regs[st_r.ptr + 4'h1];
					end
				end
				rtc_pkg::SER_SKIP: begin
					st_nxt.ser = rtc_pkg::SER_SKIP;
				end
				default: begin
					st_nxt.ser = rtc_pkg::SER_HDR;
				end
			endcase
		end

		// Events after the write so a set beats a same-cycle clear
		if (timerZero) begin
			st_nxt.regs[rtc_pkg::A_CTRL][rtc_pkg::B_TMR_FLG] = 1'b1;
		end
		if (alarmHit) begin
			st_nxt.regs[rtc_pkg::A_CTRL][rtc_pkg::B_ALM_FLG] = 1'b1;
		end

		nctl = st_nxt.regs[rtc_pkg::A_CTRL];
		if (timerZero && nctl[rtc_pkg::B_TMR_IEN] && nctl[rtc_pkg::B_PULSE_SEL]) begin
			st_nxt.rtnCnt = rtnLen;
		end else if (!nctl[rtc_pkg::B_PULSE_SEL] || !nctl[rtc_pkg::B_TMR_IEN]) begin
			st_nxt.rtnCnt = '0;
		end else if (st_r.rtnCnt != '0) begin
			st_nxt.rtnCnt = st_r.rtnCnt - rtc_pkg::RTN_W'(1);
		end

		// Several enables at once count as disabled
		case ({nctl[rtc_pkg::B_TMR_IEN], nctl[rtc_pkg::B_ALM_IEN], freqOutEn})
			3'b100: begin
				st_nxt.irqDrive = nctl[rtc_pkg::B_PULSE_SEL] ? (st_nxt.rtnCnt != '0) :
					nctl[rtc_pkg::B_TMR_FLG];
			end
			3'b010: begin
				st_nxt.irqDrive = nctl[rtc_pkg::B_ALM_FLG];
			end
			3'b001: begin
				st_nxt.irqDrive = ~freqWave;
			end
			default: begin
				st_nxt.irqDrive = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			st_r     <= '0;
			st_r.ser <= rtc_pkg::SER_HDR;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ---------------------------------------------
	// Outputs
	// ---------------------------------------------
	assign serDout   = st_r.sdo;
	assign serDoutOe = st_r.sdoOe & st_r.csS2;
	assign irqOutN   = ~st_r.irqDrive;
	assign irqOe     = st_r.irqDrive;
	assign timerFlag = ctl[rtc_pkg::B_TMR_FLG];
	assign alarmFlag = ctl[rtc_pkg::B_ALM_FLG];

	// ---------------------------------------------
	// Assertions
	// ---------------------------------------------
	logic tOnly;
	logic aOnly;
	logic noneOn;
	logic rdBit;
	logic byteEnd;
	assign tOnly   = ctl[rtc_pkg::B_TMR_IEN] & ~ctl[rtc_pkg::B_ALM_IEN] & ~freqOutEn;
	assign aOnly   = ~ctl[rtc_pkg::B_TMR_IEN] & ctl[rtc_pkg::B_ALM_IEN] & ~freqOutEn;
	assign noneOn  = ~ctl[rtc_pkg::B_TMR_IEN] & ~ctl[rtc_pkg::B_ALM_IEN] & ~freqOutEn;
	assign rdBit   = st_r.rdByte[st_r.bitCnt];
	assign byteEnd = st_r.csS2 & rise & (st_r.bitCnt == rtc_pkg::BYTE_LAST);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	sequence s_lvl;
		tOnly && !ctl[rtc_pkg::B_PULSE_SEL] && ctl[rtc_pkg::B_TMR_FLG];
	endsequence
	sequence s_alm;
		aOnly && ctl[rtc_pkg::B_ALM_FLG];
	endsequence

	a_sel_drop: assert property (!st_r.csS2 |=> st_r.ser == rtc_pkg::SER_HDR &&
		st_r.bitCnt == 3'h0)
		else $error("framing not reset on deselect");
	a_bad_mode: assert property (st_r.ser == rtc_pkg::SER_HDR && st_r.csS2 && rise &&
		st_r.bitCnt == rtc_pkg::NIB_LAST && st_nxt.shift[7:4] != rtc_pkg::MODE_WR &&
		st_nxt.shift[7:4] != rtc_pkg::MODE_RD |=> st_r.ser == rtc_pkg::SER_SKIP)
		else $error("invalid mode not ignored");
	a_wr_wrap: assert property (st_r.ser == rtc_pkg::SER_WR && byteEnd &&
		st_r.ptr == rtc_pkg::A_TOP |=> st_r.ptr == rtc_pkg::A_BOTTOM)
		else $error("pointer did not wrap");
	a_wr_store: assert property (st_r.ser == rtc_pkg::SER_WR && byteEnd &&
		st_r.ptr != rtc_pkg::A_CTRL |=> st_r.regs[$past(st_r.ptr)] == $past(st_nxt.shift)
		&& st_r.ptr == $past(st_r.ptr) + 4'h1)
		else $error("write byte not stored");
	a_rd_bit: assert property (st_r.ser == rtc_pkg::SER_RD && st_r.csS2 && rise
		|=> serDoutOe && serDout == $past(rdBit))
		else $error("read bit wrong");
	a_flag_set: assert property (timerZero |=> ctl[rtc_pkg::B_TMR_FLG])
		else $error("timer flag not set");
	a_alarm_carry: assert property ($rose(ctl[rtc_pkg::B_ALM_FLG]) |-> $past(secCarry))
		else $error("alarm outside carry");
	a_level_hold: assert property (s_lvl ##1 s_lvl |-> irqOe)
		else $error("level interrupt not held");
	a_alarm_pin: assert property (s_alm ##1 s_alm |-> irqOe)
		else $error("alarm pin not low");
	a_none_off: assert property (noneOn ##1 noneOn |-> !irqOe)
		else $error("pin driven while disabled");
	a_pulse_len: assert property (timerZero && tOnly && ctl[rtc_pkg::B_PULSE_SEL] &&
		intervalSrcSel == rtc_pkg::SRC_4096 |=>
		st_r.rtnCnt == rtc_pkg::RTN_W'(rtc_pkg::RTN_FAST_CYC))
		else $error("auto-return length wrong");

	// ---------------------------------------------
	// Pin, pointer and flag checks
	// ---------------------------------------------
	logic fOnly;
	logic ctlWr;
	assign fOnly = ~ctl[rtc_pkg::B_TMR_IEN] & ~ctl[rtc_pkg::B_ALM_IEN] & freqOutEn;
	assign ctlWr = (st_r.ser == rtc_pkg::SER_WR) & byteEnd & (st_r.ptr == rtc_pkg::A_CTRL);

	sequence s_rd_last;
		st_r.ser == rtc_pkg::SER_RD && byteEnd;
	endsequence

	a_pin_pair: assert property (irqOutN != irqOe)
		else $error("pin level and enable disagree");
	a_alarm_set: assert property (alarmHit |=> ctl[rtc_pkg::B_ALM_FLG])
		else $error("alarm flag not set");
	a_rd_wrap: assert property (s_rd_last ##0 st_r.ptr == rtc_pkg::A_TOP
		|=> st_r.ptr == rtc_pkg::A_BOTTOM)
		else $error("read pointer did not wrap");
	a_rd_step: assert property (s_rd_last
		|=> st_r.ptr == $past(st_r.ptr) + 4'h1)
		else $error("read pointer did not advance");
	a_dout_off: assert property (!st_r.csS2 |=> !serDoutOe)
		else $error("data line driven while deselected");
	a_skip_hold: assert property (st_r.ser == rtc_pkg::SER_SKIP
		|=> st_r.ptr == $past(st_r.ptr))
		else $error("ignored transfer moved the pointer");
	// Mid-write enable changes would shift the pin one cycle, so skip byte ends
	a_freq_out: assert property (fOnly && !byteEnd
		|=> irqOe == !$past(freqWave))
		else $error("frequency output wrong");

	// Flags refuse ones from the bus; only events raise them
	a_tf_no_set: assert property (ctlWr && !ctl[rtc_pkg::B_TMR_FLG] && !timerZero
		|=> !ctl[rtc_pkg::B_TMR_FLG])
		else $error("timer flag set by write");
	a_af_no_set: assert property (ctlWr && !ctl[rtc_pkg::B_ALM_FLG] && !alarmHit
		|=> !ctl[rtc_pkg::B_ALM_FLG])
		else $error("alarm flag set by write");
endmodule

//--- verilog/rtc_pkg.sv
package rtc_pkg;
	localparam int CLK_NS      = 40;
	localparam int RTN_FAST_NS = 122000;
	localparam int RTN_64_NS   = 7810000;
	localparam int RTN_1_NS    = 500000000;
	localparam int RTN_FAST_CYC = RTN_FAST_NS / CLK_NS;
	localparam int RTN_W       = 24;

	localparam logic [3:0] MODE_WR   = 4'h3;
	localparam logic [3:0] MODE_RD   = 4'hc;
	localparam logic [3:0] A_MIN     = 4'h7;
	localparam logic [3:0] A_HOUR    = 4'h8;
	localparam logic [3:0] A_WDAY    = 4'h9;
	localparam logic [3:0] A_DAY     = 4'ha;
	localparam logic [3:0] A_CTRL    = 4'he;
	localparam logic [3:0] A_TOP     = 4'hf;
	localparam logic [3:0] A_BOTTOM  = 4'h0;
	localparam logic [2:0] NIB_LAST  = 3'h3;
	localparam logic [2:0] BYTE_LAST = 3'h7;

	localparam int B_TMR_IEN   = 0;
	localparam int B_ALM_IEN   = 1;
	localparam int B_TMR_FLG   = 2;
	localparam int B_ALM_FLG   = 3;
	localparam int B_PULSE_SEL = 4;
	localparam int B_MASK = 7;

	localparam logic [1:0] SRC_4096 = 2'h0;
	localparam logic [1:0] SRC_64   = 2'h1;
	localparam logic [1:0] SRC_1    = 2'h2;
	localparam logic [1:0] SRC_MIN  = 2'h3;

	typedef enum logic [4:0] {
		SER_HDR  = 5'h01,
		SER_ADR  = 5'h02,
		SER_WR   = 5'h04,
		SER_RD   = 5'h08,
		SER_SKIP = 5'h10
	} ser_state_type;

	typedef struct packed {
		logic                   sclkS1;
		logic                   sclkS2;
		logic                   sclkD;
		logic                   csS1;
		logic                   csS2;
		logic                   sdiS1;
		logic                   sdiS2;
		ser_state_type          ser;
		logic                   isRead;
		logic [2:0]             bitCnt;
		logic [7:0]             shift;
		logic [3:0]             ptr;
		logic [7:0]             rdByte;
		logic                   sdo;
		logic                   sdoOe;
		logic [RTN_W-1:0]       rtnCnt;
		logic                   irqDrive;
		logic [15:0][7:0]       regs;
	} rtc_state_type;
endpackage

//--- verif/ser_host.sv
`timescale 1ns/1ns
// ----------------------------------------
// Serial controller model
// ----------------------------------------
module ser_host (
	// Serial pins
	output logic      serClk,
	output logic      serSel,
	output logic      serDin,
	input  wire logic serDout
);
	initial begin
		serClk = 1'b0;
		serSel = 1'b0;
		serDin = 1'b0;
	end
	// Read bit taken 310 ns after the rise, just before the next bit is driven, late enough for the sync delay
	task automatic bitIo(input logic b, output logic got);
		serDin = b;
		#160 serClk = 1'b1;
		#160 serClk = 1'b0;
		#150 got = serDout;
		#10;
	endtask
	task automatic frame(input logic [3:0] mode, input logic [3:0] adr, input int nBits,
			input logic [7:0] wr[$], output logic [7:0] rd[$]);
		logic       g;
		logic [7:0] acc;
		rd = {};
		serSel = 1'b1;
		#320;
		for (int i = 0; i < 4; i++) bitIo(mode[i], g);
		for (int i = 0; i < 4; i++) bitIo(adr[i], g);
		for (int i = 0; i < nBits; i++) begin
			// Undriven line in read mode toggles, never a stale value
			bitIo(mode == 4'hc ? ~serDin : wr[i/8][i%8], g);
			acc[i%8] = g;
			if (i % 8 == 7) rd.push_back(acc);
		end
		#160 serSel = 1'b0;
		serDin = ~serDin;
		#320;
	endtask
endmodule

//--- verif/test_rtc_irq_serial.sv
`timescale 1ns/1ns
module test_rtc_irq_serial;
	// Short auto-return counts keep the run brief
	localparam int unsigned R64 = 20;
	localparam int unsigned R1  = 40;
	logic       core_clk, nrst, freqOutEn, freqWave, timerZero, secCarry;
	logic [1:0] intervalSrcSel;
	logic [7:0] curMin, curHour, curDay;
	logic [6:0] curWday;
	logic       serClk, serSel, serDin, serDout, serDoutOe, irqOutN, irqOe;
	logic       timerFlag, alarmFlag;
	int         miscompares, total_checks, n;
	logic [15:0] lfsrState;
	logic [7:0] model[16];
	logic [7:0] wq[$], rq[$];

	rtc_irq_serial #(.RTN64_CYC(R64), .RTN1_CYC(R1)) dut_u (.core_clk, .nrst, .serClk,
		.serSel, .serDin, .serDout, .serDoutOe, .irqOutN, .irqOe, .freqOutEn,
		.intervalSrcSel, .freqWave, .timerZero, .secCarry, .curMin, .curHour,
		.curWday, .curDay, .timerFlag, .alarmFlag);
	ser_host host_u (.serClk, .serSel, .serDin, .serDout);

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	initial begin
		#3000000;
		miscompares++;
		conclude();
	end
	function automatic logic [15:0] nextRnd(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic rnd();
		lfsrState = nextRnd(lfsrState);
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic wrReg(input logic [3:0] a, input logic [7:0] d[$]);
		host_u.frame(4'h3, a, 8 * d.size(), d, rq);
		foreach (d[i]) model[4'(a + i)] = d[i];
	endtask
	task automatic rdCmp(input logic [3:0] a, input int k);
		host_u.frame(4'hc, a, 8 * k, wq, rq);
		for (int i = 0; i < k; i++) chk(rq[i], model[4'(a + i)]);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	initial begin
		{nrst, freqOutEn, freqWave, timerZero, secCarry, intervalSrcSel} = '0;
		{curMin, curHour, curDay, curWday} = '0;
		miscompares = 0;
		total_checks = 0;
		lfsrState = 16'h0063;
		foreach (model[i]) model[i] = 8'h00;
		tick(12);
		nrst = 1'b1;
		tick(3);
		chk({irqOe, irqOutN, timerFlag, alarmFlag}, 4'h4);
		wq = {};
		repeat (4) begin
			rnd();
			wq.push_back(lfsrState[7:0]);
		end
		wrReg(4'hf, wq);
		rdCmp(4'hf, 4);
		host_u.frame(4'h3, 4'h1, 5, {8'h5a}, rq);
		rdCmp(4'h1, 1);
		host_u.frame(4'h5, 4'h2, 16, {8'ha5, 8'h3c}, rq);
		rdCmp(4'h2, 1);
		$display("serial test done");
		wrReg(4'he, {8'h01});
		pulse(timerZero);
		tick(2);
		chk({irqOe, irqOutN, timerFlag}, 3'b101);
		tick(50);
		chk(irqOe, 1'b1);
		wrReg(4'he, {8'h05});
		chk({irqOe, timerFlag}, 2'b11);
		wrReg(4'he, {8'h01});
		chk({irqOe, timerFlag}, 2'b00);
		wrReg(4'he, {8'h11});
		for (int s = 0; s < 4; s++) begin
			intervalSrcSel = s[1:0];
			pulse(timerZero);
			n = 0;
			for (int k = 0; k < 4000; k++) begin
				if (irqOe === 1'b1) n++;
				else if (n > 0) break;
				tick(1);
			end
			chk(n, s == 1 ? R64 : s == 2 ? R1 : rtc_pkg::RTN_FAST_CYC);
			chk(timerFlag, 1'b1);
		end
		wrReg(4'he, {8'h10});
		pulse(timerZero);
		tick(3);
		chk({irqOe, timerFlag}, 2'b01);
		$display("timer test done");
		wrReg(4'he, {8'h00});
		wrReg(4'h7, {8'h25, 8'h80, 8'h80, 8'h80});
		wrReg(4'he, {8'h02});
		curMin = 8'h24;
		pulse(secCarry);
		tick(2);
		chk({irqOe, alarmFlag}, 2'b00);
		curMin = 8'h25;
		tick(20);
		chk({irqOe, alarmFlag}, 2'b00);
		pulse(secCarry);
		tick(2);
		chk({irqOe, irqOutN, alarmFlag}, 3'b101);
		wrReg(4'he, {8'h00});
		chk({irqOe, alarmFlag}, 2'b00);
		pulse(secCarry);
		tick(2);
		chk({irqOe, alarmFlag}, 2'b01);
		$display("alarm test done");
		freqOutEn = 1'b1;
		repeat (8) begin
			rnd();
			freqWave = lfsrState[0];
			tick(3);
			chk(irqOe, {~freqWave});
		end
		wrReg(4'he, {8'h01});
		pulse(timerZero);
		tick(2);
		chk(irqOe, 1'b0);
		$display("output select test done");
		conclude();
	end
endmodule
